// ==== rtl/sfc_defs.svh ====
// Opcodes, status bit positions and timing counts of the command block
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
`define SFC_OP_LATCH_ARM    8'h06
`define SFC_OP_LATCH_DISARM 8'h04
`define SFC_OP_STAT_STORE   8'h01
`define SFC_OP_STAT_FETCH   8'h05
`define SFC_OP_SMALL_WIPE   8'h20
`define SFC_OP_MID_WIPE_A   8'h52
`define SFC_OP_MID_WIPE_B   8'hD8
`define SFC_OP_ALL_WIPE_A   8'h60
`define SFC_OP_ALL_WIPE_B   8'hC7
`define SFC_OP_PAGE_WRITE   8'h02
`define SFC_OP_SLEEP_ENTRY  8'hB9
`define SFC_OP_SLEEP_EXIT   8'hAB
`define SFC_OP_MAKER_PART   8'h90
`define SFC_OP_TWO_LANE     8'h3B
`define SFC_OP_PARAM_TABLE  8'h5A
`define SFC_BIT_BUSY        0
`define SFC_BIT_LATCH       1
`define SFC_BIT_PL_LO       2
`define SFC_BIT_PL_HI       3
`define SFC_BIT_LOCK        7
`define SFC_ADDR_BYTES      3'h4
`define SFC_DATA_START      4'h5
`define SFC_ID_START        4'h4
`define SFC_CLK_NS          10
`define SFC_BUSY_NS         10000
`define SFC_BUSY_CYC        ((`SFC_BUSY_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`endif

// ==== rtl/sfc_pkg.sv ====
// Types shared by the command block
package sfc_pkg;
   typedef enum logic [1:0] {
      SFC_ARR_PAGE  = 2'b00,
      SFC_ARR_SMALL = 2'b01,
      SFC_ARR_MID   = 2'b10,
      SFC_ARR_ALL   = 2'b11
   } sfc_arr_op_t;
   typedef enum logic {
      SFC_ST_IDLE = 1'b0,
      SFC_ST_BUSY = 1'b1
   } sfc_state_t;
endpackage : sfc_pkg

// ==== rtl/sfc_cmd_status.sv ====
// Serial flash command decoder and status register
`timescale 1ns/100ps
`include "sfc_defs.svh"

// Functional notes
// - Wipe opcodes: small 20h, mid 52h/D8h with address; whole 60h/C7h without.
// - Two-lane read 3Bh: address, dummy byte, then data on two lines.
// - ABh: three don't-care bytes, then the part identification byte.
// - 90h: fourth byte bit picks maker-first (0) or part-first (1).
// - B9h enters deep sleep; ABh leaves it.
// - Latch-arm sets the write latch; needed before each altering command.
// - Latch-disarm clears the write latch on completion.
// - Latch clears at reset and after disarm, store, page write, wipes.
// - Status fetch is accepted anytime and repeats while select is low.
// - Status bit 0 is busy during program, erase or status write.
// - Status bit 1 is write latch; clear latch refuses altering commands.
// - Bits 3:2 protect level, non-volatile, changed only by status store.
// - Whole-array wipe runs only when protect level is zero.
// - Lock bit 7 with protect pin low blocks status store.
// - Level 0 none, 1 top block, 2 top two blocks, 3 all.
// - Altering commands and sleep entry must end on a byte boundary.
// - Status write starts at select rise; busy then clears with latch.
// - Unknown opcode leaves output released until next frame.
module sfc_cmd_status
   import sfc_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value
   parameter logic [7:0] PART_ID  = 8'h3C  // Arbitrary value
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_si,
   input  wire logic        i_wp_n,
   input  wire logic [7:0]  i_rd_byte,
   output logic             o_so,
   output logic             o_so_oe_n,
   output logic             o_io0,
   output logic             o_io0_oe_n,
   output logic [23:0]      o_rd_addr,
   output logic [7:0]       o_status,
   output logic             o_sleep,
   output logic             o_array_go,
   output logic [1:0]       o_array_op,
   output logic [23:0]      o_array_addr
);

   ////////////////////////////////////////////////////////////////////////////
   // Link side, rising serial clock
   logic        live_reg, live_next;
   logic        tog_reg, tog_next;
   logic [2:0]  bit_reg, bit_next;
   logic [2:0]  byte_reg, byte_next;
   logic [6:0]  shin_reg, shin_next;
   logic [7:0]  op_reg, op_next;
   logic [23:0] addr_reg, addr_next;
   logic [7:0]  data1_reg, data1_next;
   logic        dead_reg, dead_next;
   logic        id_reg, id_next;
   logic        txon_reg, txon_next;
   logic        dual_reg, dual_next;
   logic [7:0]  txb_reg, txb_next;
   logic [8:0]  ss1_reg, ss2_reg, ss3_reg, ssu_reg, ssu_next;
   logic        sleep_reg; // System-side sleep level, sampled into the link status copy
   logic [7:0]  in_byte, cur_op;
   logic [2:0]  bc, bits;
   logic [3:0]  n;
   logic        last, cur_id, known;

   // Opcode recognition; anything else is an undefined code
   function automatic logic sfc_known(input logic [7:0] op);
      case (op)
         `SFC_OP_LATCH_ARM, `SFC_OP_LATCH_DISARM, `SFC_OP_STAT_STORE,
         `SFC_OP_STAT_FETCH, `SFC_OP_SMALL_WIPE, `SFC_OP_MID_WIPE_A,
         `SFC_OP_MID_WIPE_B, `SFC_OP_ALL_WIPE_A, `SFC_OP_ALL_WIPE_B,
         `SFC_OP_PAGE_WRITE, `SFC_OP_SLEEP_ENTRY, `SFC_OP_SLEEP_EXIT,
         `SFC_OP_MAKER_PART, `SFC_OP_TWO_LANE, `SFC_OP_PARAM_TABLE: sfc_known = 1'b1;
         default: sfc_known = 1'b0;
      endcase
   endfunction : sfc_known

   // Byte assembly, capture and choice of the next byte to shift out
   always_comb begin
      bc        = live_reg ? byte_reg : 3'h0;
      bits      = live_reg ? bit_reg : 3'h0;
      in_byte   = {shin_reg, i_si};
      cur_op    = (bc == 3'h0) ? in_byte : op_reg;
      n         = {1'b0, bc} + 4'h1;
      known     = sfc_known(in_byte);
      cur_id    = (bc == 3'h3) ? in_byte[0] : id_reg;
      last      = (live_reg && dual_reg) ? (bits == 3'h3) : (bits == 3'h7);
      live_next = 1'b1;
      tog_next  = live_reg ? tog_reg : ~tog_reg;
      shin_next = {shin_reg[5:0], i_si};
      bit_next  = last ? 3'h0 : bits + 3'h1;
      byte_next = bc;
      op_next   = op_reg;
      addr_next = addr_reg;
      data1_next = data1_reg;
      dead_next = live_reg & dead_reg;
      id_next   = id_reg;
      txon_next = live_reg & txon_reg;
      dual_next = live_reg & dual_reg;
      txb_next  = txb_reg;
      ssu_next  = (ss2_reg == ss3_reg) ? ss3_reg : ssu_reg;
      if (last) begin
         byte_next = (bc == 3'h7) ? 3'h7 : bc + 3'h1;
         if (bc == 3'h0) begin
            op_next   = in_byte;
            dead_next = ~known;
         end
         if (bc == 3'h1) begin
            data1_next = in_byte;
         end
         if (bc != 3'h0 && bc < 3'h4) begin
            addr_next = {addr_reg[15:0], in_byte};
         end
         txon_next = 1'b0;
         if (!dead_next) begin
            case (cur_op)
               `SFC_OP_STAT_FETCH: begin
                  txon_next = 1'b1;
                  txb_next  = ssu_reg[7:0];
               end
               `SFC_OP_SLEEP_EXIT: begin
                  if (n >= `SFC_ID_START) begin
                     txon_next = 1'b1;
                     txb_next  = PART_ID;
                  end
               end
               `SFC_OP_MAKER_PART: begin
                  if (!ssu_reg[8] && n >= `SFC_ID_START) begin
                     txon_next = 1'b1;
                     txb_next  = cur_id ? PART_ID : MAKER_ID;
                     id_next   = ~cur_id;
                  end
               end
               `SFC_OP_TWO_LANE, `SFC_OP_PARAM_TABLE: begin
                  if (!ssu_reg[8] && !ssu_reg[`SFC_BIT_BUSY] && n >= `SFC_DATA_START) begin
                     txon_next = 1'b1;
                     txb_next  = i_rd_byte;
                     dual_next = (cur_op == `SFC_OP_TWO_LANE);
                     addr_next = addr_reg + 24'h1;
                  end
               end
               default: begin
                  txon_next = 1'b0;
               end
            endcase
         end
      end
   end

   // Fields read by the system side stay put while select is high
   always_ff @(posedge i_sclk or posedge i_rst) begin
      if (i_rst) begin
         tog_reg   <= 1'b0;
         bit_reg   <= 3'h0;
         byte_reg  <= 3'h0;
         shin_reg  <= 7'h00;
         op_reg    <= 8'h00;
         addr_reg  <= 24'h000000;
         data1_reg <= 8'h00;
         ss1_reg   <= 9'h000;
         ss2_reg   <= 9'h000;
         ss3_reg   <= 9'h000;
         ssu_reg   <= 9'h000;
      end else begin
         tog_reg   <= tog_next;
         bit_reg   <= bit_next;
         byte_reg  <= byte_next;
         shin_reg  <= shin_next;
         op_reg    <= op_next;
         addr_reg  <= addr_next;
         data1_reg <= data1_next;
         ss1_reg   <= {sleep_reg, o_status};
         ss2_reg   <= ss1_reg;
         ss3_reg   <= ss2_reg;
         ssu_reg   <= ssu_next;
      end
   end

   // Per-frame state; select high restarts parsing
   always_ff @(posedge i_sclk or posedge i_rst or posedge i_cs_n) begin
      if (i_rst || i_cs_n) begin
         live_reg <= 1'b0;
         dead_reg <= 1'b0;
         id_reg   <= 1'b0;
         txon_reg <= 1'b0;
         dual_reg <= 1'b0;
         txb_reg  <= 8'h00;
      end else begin
         live_reg <= live_next;
         dead_reg <= dead_next;
         id_reg   <= id_next;
         txon_reg <= txon_next;
         dual_reg <= dual_next;
         txb_reg  <= txb_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link side, falling serial clock: output shifter
   logic [7:0] sh_reg, sh_next, src;
   logic       so_next, io0_next, so_oe_next, io0_oe_next;

   // A fresh byte loads when the bit counter has wrapped
   always_comb begin
      src = (bit_reg == 3'h0) ? txb_reg : sh_reg;
      so_next     = src[7];
      io0_next    = dual_reg & src[6];
      sh_next     = dual_reg ? {src[5:0], 2'b00} : {src[6:0], 1'b0};
      so_oe_next  = ~txon_reg;
      io0_oe_next = ~(txon_reg & dual_reg);
   end

   // Released whenever select is high
   always_ff @(negedge i_sclk or posedge i_rst or posedge i_cs_n) begin
      if (i_rst || i_cs_n) begin
         sh_reg     <= 8'h00;
         o_so       <= 1'b0;
         o_io0      <= 1'b0;
         o_so_oe_n  <= 1'b1;
         o_io0_oe_n <= 1'b1;
         o_rd_addr  <= 24'h000000;
      end else begin
         sh_reg     <= sh_next;
         o_so       <= so_next;
         o_io0      <= io0_next;
         o_so_oe_n  <= so_oe_next;
         o_io0_oe_n <= io0_oe_next;
         o_rd_addr  <= addr_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System side: synchronisers, execution at select rise, status
   logic [2:0]  cs_sy_reg, wp_sy_reg, tg_sy_reg;
   logic        cs_q_reg, cs_q_next, wp_q_reg, wp_q_next, tg_q_reg, tg_q_next;
   logic        dtog_reg, dtog_next;
   sfc_state_t  st_reg, st_next;
   logic [11:0] bcnt_reg, bcnt_next;
   logic        wl_reg, wl_next, lock_reg, lock_next, sleep_next;
   logic [1:0]  pl_reg, pl_next;
   logic        go_next;
   logic [1:0]  aop_next;
   logic [23:0] aadr_next;
   logic        rise, exec, aligned, prot, go_ok;

   // Command completion; link fields are static once select is high
   always_comb begin
      cs_q_next = (cs_sy_reg[1] == cs_sy_reg[2]) ? cs_sy_reg[2] : cs_q_reg;
      wp_q_next = (wp_sy_reg[1] == wp_sy_reg[2]) ? wp_sy_reg[2] : wp_q_reg;
      tg_q_next = (tg_sy_reg[1] == tg_sy_reg[2]) ? tg_sy_reg[2] : tg_q_reg;
      rise      = ~cs_q_reg & cs_q_next;
      exec      = rise & (tg_q_reg != dtog_reg);
      dtog_next = exec ? tg_q_reg : dtog_reg;
      aligned   = (bit_reg == 3'h0) & ~dead_reg;
      prot      = (pl_reg == 2'h3) || (pl_reg == 2'h2 && addr_reg[17]) ||
                  (pl_reg == 2'h1 && addr_reg[17:16] == 2'h3);
      go_ok     = wl_reg & ~prot;
      st_next   = st_reg;
      bcnt_next = bcnt_reg;
      wl_next   = wl_reg;
      pl_next   = pl_reg;
      lock_next = lock_reg;
      sleep_next = sleep_reg;
      go_next   = 1'b0;
      aop_next  = o_array_op;
      aadr_next = o_array_addr;
      case (st_reg)
         SFC_ST_IDLE: begin
            if (exec && op_reg == `SFC_OP_SLEEP_EXIT && byte_reg != 3'h0) begin
               sleep_next = 1'b0;
            end else if (exec && aligned && !sleep_reg) begin
               case (op_reg)
                  `SFC_OP_LATCH_ARM:    wl_next = (byte_reg == 3'h1) | wl_reg;
                  `SFC_OP_LATCH_DISARM: wl_next = (byte_reg != 3'h1) & wl_reg;
                  `SFC_OP_SLEEP_ENTRY:  sleep_next = (byte_reg == 3'h1) | sleep_reg;
                  `SFC_OP_STAT_STORE: begin
                     if (byte_reg == 3'h2 && wl_reg && !(lock_reg && !wp_q_reg)) begin
                        pl_next   = {data1_reg[`SFC_BIT_PL_HI], data1_reg[`SFC_BIT_PL_LO]};
                        lock_next = data1_reg[`SFC_BIT_LOCK];
                        st_next   = SFC_ST_BUSY;
                     end
                  end
                  `SFC_OP_SMALL_WIPE, `SFC_OP_MID_WIPE_A, `SFC_OP_MID_WIPE_B: begin
                     if (byte_reg == `SFC_ADDR_BYTES && go_ok) begin
                        go_next  = 1'b1;
                        aop_next = (op_reg == `SFC_OP_SMALL_WIPE) ? SFC_ARR_SMALL : SFC_ARR_MID;
                        st_next  = SFC_ST_BUSY;
                     end
                  end
                  `SFC_OP_ALL_WIPE_A, `SFC_OP_ALL_WIPE_B: begin
                     if (byte_reg == 3'h1 && wl_reg && pl_reg == 2'h0) begin
                        go_next  = 1'b1;
                        aop_next = SFC_ARR_ALL;
                        st_next  = SFC_ST_BUSY;
                     end
                  end
                  `SFC_OP_PAGE_WRITE: begin
                     if (byte_reg > `SFC_ADDR_BYTES && go_ok) begin
                        go_next  = 1'b1;
                        aop_next = SFC_ARR_PAGE;
                        st_next  = SFC_ST_BUSY;
                     end
                  end
                  default: wl_next = wl_reg;
               endcase
               aadr_next = go_next ? addr_reg : o_array_addr;
               bcnt_next = 12'(`SFC_BUSY_CYC);
            end
         end
         SFC_ST_BUSY: begin
            // New commands are ignored until the cycle ends
            bcnt_next = bcnt_reg - 12'h001;
            if (bcnt_reg <= 12'h001) begin
               st_next = SFC_ST_IDLE;
               wl_next = 1'b0;
            end
         end
         default: st_next = SFC_ST_IDLE;
      endcase
   end

   // Protect bits model non-volatile cells; they reset here for simulation only
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cs_sy_reg    <= 3'b111;
         wp_sy_reg    <= 3'b111;
         tg_sy_reg    <= 3'b000;
         cs_q_reg     <= 1'b1;
         wp_q_reg     <= 1'b1;
         tg_q_reg     <= 1'b0;
         dtog_reg     <= 1'b0;
         st_reg       <= SFC_ST_IDLE;
         bcnt_reg     <= 12'h000;
         wl_reg       <= 1'b0;
         pl_reg       <= 2'h0;
         lock_reg     <= 1'b0;
         sleep_reg    <= 1'b0;
         o_array_go   <= 1'b0;
         o_array_op   <= SFC_ARR_PAGE;
         o_array_addr <= 24'h000000;
         o_status     <= 8'h00;
         o_sleep      <= 1'b0;
      end else begin
         cs_sy_reg    <= {cs_sy_reg[1:0], i_cs_n};
         wp_sy_reg    <= {wp_sy_reg[1:0], i_wp_n};
         tg_sy_reg    <= {tg_sy_reg[1:0], tog_reg};
         cs_q_reg     <= cs_q_next;
         wp_q_reg     <= wp_q_next;
         tg_q_reg     <= tg_q_next;
         dtog_reg     <= dtog_next;
         st_reg       <= st_next;
         bcnt_reg     <= bcnt_next;
         wl_reg       <= wl_next;
         pl_reg       <= pl_next;
         lock_reg     <= lock_next;
         sleep_reg    <= sleep_next;
         o_array_go   <= go_next;
         o_array_op   <= aop_next;
         o_array_addr <= aadr_next;
         o_status     <= {lock_next, 3'b000, pl_next, wl_next, st_next == SFC_ST_BUSY};
         o_sleep      <= sleep_next;
      end
   end

endmodule : sfc_cmd_status

// ==== verif/sfc_host_model.sv ====
// Host serial controller model that drives the link side
`timescale 1ns/100ps
module sfc_host_model (
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_si,
   input  wire logic i_so,
   input  wire logic i_io0,
   input  wire logic i_so_oe_n
);
   logic [7:0] tx [8];
   logic [7:0] rx [8];
   logic [7:0] rx0 [8];
   logic       seen_drv;
   // Idle link: clock low, select high
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b1;
      seen_drv = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   // One frame at 160 ns per bit; the clock stands still between frames
   task automatic frame(input int nbits);
      o_cs_n = 1'b0;
      seen_drv = 1'b0;
      #80;
      for (int i = 0; i < nbits; i++) begin
         o_si = tx[i/8][7-i%8];
         #80 o_sclk = 1'b1;
         rx[i/8][7-i%8] = i_so;
         rx0[i/8][7-i%8] = i_io0;
         if (i_so_oe_n === 1'b0) seen_drv = 1'b1;
         #80 o_sclk = 1'b0;
      end
      #80 o_cs_n = 1'b1;
      o_si = ~o_si; // Released line never keeps its last value
      #120;
   endtask : frame
endmodule : sfc_host_model

// ==== verif/sfc_cmd_status_asserts.sv ====
// Concurrent checks on the command block ports
`timescale 1ns/100ps
module sfc_cmd_status_asserts (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_cs_n,
   input wire logic       i_wp_n,
   input wire logic       o_so_oe_n,
   input wire logic       o_io0_oe_n,
   input wire logic [7:0] o_status,
   input wire logic       o_sleep,
   input wire logic       o_array_go,
   input wire logic [1:0] o_array_op
);
   localparam int BUSY_LO = 990;
   localparam int BUSY_HI = 1010;
   logic [10:0] busy_cnt_reg;
   logic [10:0] busy_cnt_next;
   // Busy span counter; saturates so a stuck flag cannot wrap into range
   always_comb begin
      busy_cnt_next = 11'h000;
      if (o_status[0] && busy_cnt_reg != 11'h7FF) busy_cnt_next = busy_cnt_reg + 11'h001;
      else if (o_status[0]) busy_cnt_next = busy_cnt_reg;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) busy_cnt_reg <= 11'h000;
      else busy_cnt_reg <= busy_cnt_next;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////
   chk_resv_zero: assert property (o_status[6:4] == 3'h0)
      else $error("reserved status bits set");
   chk_go_latch: assert property (o_array_go |-> $past(o_status[1]))
      else $error("array op without write latch");
   chk_go_busy: assert property (o_array_go |-> ##[0:2] o_status[0])
      else $error("array op without busy");
   chk_all_level: assert property (o_array_go && o_array_op == 2'h3 |-> o_status[3:2] == 2'h0)
      else $error("whole wipe under protection");
   chk_busy_end: assert property ($fell(o_status[0]) |-> !o_status[1])
      else $error("latch left set after busy");
   chk_busy_span: assert property ($fell(o_status[0]) |-> busy_cnt_reg >= BUSY_LO && busy_cnt_reg <= BUSY_HI)
      else $error("busy span wrong");
   chk_hard_lock: assert property ((o_status[7] && !i_wp_n)[*6] |=> $stable(o_status[7:2]))
      else $error("locked status changed");
   chk_idle_release: assert property (i_cs_n |-> o_so_oe_n && o_io0_oe_n)
      else $error("output driven while deselected");
   chk_sleep_quiet: assert property (o_sleep |-> !o_array_go)
      else $error("array op while asleep");
   cov_go: cover property (o_array_go);
   cov_busy_done: cover property ($fell(o_status[0]));
   cov_sleep: cover property ($rose(o_sleep));
endmodule : sfc_cmd_status_asserts
bind sfc_cmd_status sfc_cmd_status_asserts u_chk (.i_clk, .i_rst, .i_cs_n, .i_wp_n, .o_so_oe_n,
   .o_io0_oe_n, .o_status, .o_sleep, .o_array_go, .o_array_op);

// ==== verif/test_serial_flash_cmd_status.sv ====
// Self-checking bench for the serial flash command block
`timescale 1ns/100ps
`include "sfc_defs.svh"
module test_serial_flash_cmd_status
   import sfc_pkg::*;
;
   localparam logic [7:0] MAKER = 8'h5E; // Arbitrary value
   localparam logic [7:0] PART = 8'hC3;  // Arbitrary value
   logic        i_clk = 1'b0, i_rst = 1'b1, i_wp_n = 1'b1;
   logic        sclk, cs_n, si, so, so_oe_n, io0, io0_oe_n, sleep, go;
   logic [7:0]  status, rd_byte;
   logic [23:0] rd_addr, arr_addr, go_addr;
   logic [1:0]  arr_op, go_op;
   int          fails = 0, samples_checked = 0, go_cnt = 0, seed = 32'h6E3E;
   sfc_cmd_status #(.MAKER_ID(MAKER), .PART_ID(PART)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n), .i_rd_byte(rd_byte), .o_so(so),
      .o_so_oe_n(so_oe_n), .o_io0(io0), .o_io0_oe_n(io0_oe_n), .o_rd_addr(rd_addr),
      .o_status(status), .o_sleep(sleep), .o_array_go(go), .o_array_op(arr_op),
      .o_array_addr(arr_addr));
   sfc_host_model u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_io0(io0),
      .i_so_oe_n(so_oe_n));
   always #5 i_clk = ~i_clk;
   assign rd_byte = rd_model(rd_addr);
   // Capture each one-cycle array pulse
   always @(posedge i_clk) begin
      if (go === 1'b1) begin
         go_cnt <= go_cnt + 1;
         go_op <= arr_op;
         go_addr <= arr_addr;
      end
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rd_model(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction : rd_model
   function automatic logic [7:0] lanes(input logic [3:0] hi, input logic [3:0] lo);
      return {hi[3], lo[3], hi[2], lo[2], hi[1], lo[1], hi[0], lo[0]};
   endfunction : lanes
   function automatic logic [1:0] exp_op(input logic [7:0] op);
      case (op)
         `SFC_OP_SMALL_WIPE: return SFC_ARR_SMALL;
         `SFC_OP_MID_WIPE_A, `SFC_OP_MID_WIPE_B: return SFC_ARR_MID;
         `SFC_OP_ALL_WIPE_A, `SFC_OP_ALL_WIPE_B: return SFC_ARR_ALL;
         default: return SFC_ARR_PAGE;
      endcase
   endfunction : exp_op
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t byte %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte
   task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask : cmp_word
   // Frames end off the clock edge, so flags have settled when looked at
   task automatic send(input logic [39:0] b, input int nbits);
      for (int k = 0; k < 5; k++) u_host.tx[k] = b[39-8*k -: 8];
      u_host.frame(nbits);
      repeat (10) @(negedge i_clk);
   endtask : send
   // Third status byte is used; the first may predate the link-side sync
   task automatic fetch(output logic [7:0] st);
      send({`SFC_OP_STAT_FETCH, 32'h0}, 32);
      st = u_host.rx[3];
   endtask : fetch
   task automatic st_chk(input logic [7:0] exp);
      logic [7:0] st;
      fetch(st);
      cmp_byte(st, exp);
   endtask : st_chk
   task automatic wait_idle();
      logic [7:0] st;
      fetch(st);
      cmp_byte({7'h0, st[0]}, 8'h01);
      for (int t = 0; t < 60 && st[0] !== 1'b0; t++) fetch(st);
   endtask : wait_idle
   task automatic arm();
      send({`SFC_OP_LATCH_ARM, 32'h0}, 8);
   endtask : arm
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////
   initial begin
      #900000;
      fails++;
      $display("BAD %0t watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      logic [23:0] a;
      logic [7:0]  ops [6];
      ops = '{`SFC_OP_PAGE_WRITE, `SFC_OP_SMALL_WIPE, `SFC_OP_MID_WIPE_A, `SFC_OP_MID_WIPE_B,
         `SFC_OP_ALL_WIPE_A, `SFC_OP_ALL_WIPE_B};
      u_host.tx[5] = 8'h00;
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk);
      cmp_byte(status, 8'h00);
      // Refusals: no latch, then a frame cut off the byte boundary
      send({`SFC_OP_PAGE_WRITE, 32'h0001_0203}, 40);
      cmp_word(24'(go_cnt), 24'h0);
      send({`SFC_OP_LATCH_ARM, 32'h0}, 9);
      st_chk(8'h00);
      arm();
      st_chk(8'h02);
      send({`SFC_OP_LATCH_DISARM, 32'h0}, 8);
      st_chk(8'h00);
      // Every array opcode, the addressed ones at a random address
      foreach (ops[k]) begin
         a = 24'($random(seed));
         arm();
         send({ops[k], a, 8'h5A}, (k >= 4) ? 8 : ((k == 0) ? 40 : 32));
         cmp_word(24'(go_cnt), 24'(k + 1));
         cmp_byte({6'h0, go_op}, {6'h0, exp_op(ops[k])});
         if (k < 4) cmp_word(go_addr, a);
         wait_idle();
         st_chk(8'h00);
      end
      // Lock with full protection; whole wipe and locked store refused
      arm();
      send({`SFC_OP_STAT_STORE, 8'h8C, 24'h0}, 16);
      wait_idle();
      st_chk(8'h8C);
      arm();
      send({`SFC_OP_ALL_WIPE_B, 32'h0}, 8);
      st_chk(8'h8E);
      i_wp_n = 1'b0;
      send({`SFC_OP_STAT_STORE, 8'h04, 24'h0}, 16);
      st_chk(8'h8E);
      i_wp_n = 1'b1;
      send({`SFC_OP_STAT_STORE, 8'h04, 24'h0}, 16);
      wait_idle();
      st_chk(8'h04);
      // Level one guards only the top block
      arm();
      send({`SFC_OP_PAGE_WRITE, 24'h030000, 8'h11}, 40);
      cmp_word(24'(go_cnt), 24'h6);
      send({`SFC_OP_PAGE_WRITE, 24'h020000, 8'h11}, 40);
      cmp_word(24'(go_cnt), 24'h7);
      wait_idle();
      arm();
      send({`SFC_OP_STAT_STORE, 8'h00, 24'h0}, 16);
      wait_idle();
      // Identification reads
      send({`SFC_OP_SLEEP_EXIT, 32'h0}, 40);
      cmp_byte(u_host.rx[4], PART);
      for (int o = 0; o < 2; o++) begin
         send({`SFC_OP_MAKER_PART, 16'h0, 7'h0, o[0], 8'h0}, 48);
         cmp_byte(u_host.rx[4], o[0] ? PART : MAKER);
         cmp_byte(u_host.rx[5], o[0] ? MAKER : PART);
      end
      // Two-lane read of two bytes
      a = 24'($random(seed));
      send({`SFC_OP_TWO_LANE, a, 8'h0}, 48);
      cmp_byte(lanes(u_host.rx[5][7:4], u_host.rx0[5][7:4]), rd_model(a));
      cmp_byte(lanes(u_host.rx[5][3:0], u_host.rx0[5][3:0]), rd_model(a + 24'h1));
      // Parameter-table read streams one lane after the dummy byte
      a = 24'($random(seed));
      send({`SFC_OP_PARAM_TABLE, a, 8'h0}, 48);
      cmp_byte(u_host.rx[5], rd_model(a));
      // Sleep and wake, then an undefined opcode
      send({`SFC_OP_SLEEP_ENTRY, 32'h0}, 8);
      cmp_byte({7'h0, sleep}, 8'h01);
      send({`SFC_OP_SLEEP_EXIT, 32'h0}, 8);
      cmp_byte({7'h0, sleep}, 8'h00);
      send({8'hE7, 32'h0}, 16);
      cmp_byte({7'h0, u_host.seen_drv}, 8'h00);
      tally_and_finish();
   end
endmodule : test_serial_flash_cmd_status
